//--- uestb_pkg.sv
/*
  uestb_pkg: constants and types for the usb error status and table base block.
  Assumes a single 200 MHz system clock shared with the packet engine.
*/
package uestb_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] FLAGS_OFFSET = 8'h00;
  localparam logic [7:0] PAGE1_OFFSET = 8'h04;
  localparam logic [7:0] PAGE2_OFFSET = 8'h08;
  localparam logic [7:0] PAGE3_OFFSET = 8'h0C;

  // error flag bit positions
  localparam int BIT_STUFF_POS = 7;
  localparam int BUS_MATRIX_POS = 6;
  localparam int MEM_SERVICE_POS = 5;
  localparam int TURNAROUND_POS = 4;
  localparam int DATA_SIZE_POS = 3;
  localparam int DATA_CRC_POS = 2;
  localparam int TOKEN_CRC_POS = 1;
  localparam int PID_CHECK_POS = 0;

  // reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [6:0] PAGE1_RESET = 7'h00;

  // table base layout
  localparam int BASE_ALIGN_BITS = 9;
  localparam logic [8:0] BASE_LOW_ZERO = 9'h000;

  // idle bit times tolerated after an end of packet
  localparam logic [4:0] TURN_LIMIT = 5'h10;

  // per-packet events from the packet engine, one-cycle pulses
  typedef struct packed {
    logic bit_stuff;
    logic table_fault;
    logic grant_late;
    logic rx_truncated;
    logic data_end;
    logic [2:0] data_bits_mod8;
    logic data_crc_bad;
    logic token_end;
    logic token_crc_bad;
    logic pid_strobe;
    logic [7:0] pid_byte;
  } uestb_evt_type;

  // frame timing status from the engine
  typedef struct packed {
    logic host_mode;
    logic sof_zero;
    logic tx_busy;
    logic rx_busy;
  } uestb_frame_type;

endpackage : uestb_pkg

//--- uestb_turn_timer.sv
/*
  uestb_turn_timer: counts idle bit times after an end of packet while a
  response is awaited and pulses once when the tolerated count is passed.
  Assumes bit_tick, eop_seen, await_resp and bus_idle come from sys_clk logic.
*/
module uestb_turn_timer (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic eop_seen, // end of packet pulse
  input wire logic await_resp, // response expected
  input wire logic bus_idle, // line idle
  input wire logic bit_tick, // one pulse per bit time
  output logic timeout_q // time-out pulse
);

  logic [4:0] count_q;
  logic [4:0] count_d;
  logic armed_q;
  logic armed_d;
  logic timeout_d;

  wire watching = armed_q && await_resp && bus_idle;
  wire reach = watching && bit_tick && (count_q == uestb_pkg::TURN_LIMIT);

  // restart on every end of packet, stop once the answer starts
  assign armed_d = eop_seen ? 1'b1 : (reach || !await_resp || !bus_idle) ? 1'b0 : armed_q;
  assign count_d = eop_seen ? 5'h00 : (watching && bit_tick) ? count_q + 5'h01 : count_q;
  assign timeout_d = reach;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 5'h00;
      armed_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      count_q <= count_d;
      armed_q <= armed_d;
      timeout_q <= timeout_d;
    end
  end

  property p_turn_count;
    @(posedge sys_clk) disable iff (!arst_n)
    timeout_q |-> $past(count_q) == uestb_pkg::TURN_LIMIT && $past(bit_tick);
  endproperty
  a_turn_count: assert property (p_turn_count) else $error("time-out without 17th bit time");

endmodule : uestb_turn_timer

//--- uestb_core.sv
/*
  uestb_core: sticky usb packet error flags with write-one-to-clear and the
  page registers that form the descriptor table base address.
  Assumes the packet engine drives all event inputs on sys_clk as one-cycle
  pulses and that the register master follows the plain strobe protocol.
*/
// Operation
// - bit stuff error rejects packet, sets bit 7
// - bad table or buffer address sets bit 6
// - late grant or truncation sets bit 5
// - over 16 idle bit times sets bit 4
// - partial-byte data field sets bit 3
// - bad CRC16 rejects data, sets bit 2
// - device mode: bad CRC5 token, bit 1
// - host mode: busy at frame end, bit 1
// - failed PID check sets bit 0
// - flags sticky until software writes one
// - upper 24 bits ignore writes, read zero
// - page 2 holds base bits 23 to 16
// - table base is 512-byte aligned
// - page 3 holds base bits 31 to 24
module uestb_core (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata_q, // read data, cycle after strobe
  input wire uestb_pkg::uestb_evt_type evt, // packet events
  input wire uestb_pkg::uestb_frame_type frame, // frame status
  input wire logic eop_seen, // end of packet pulse
  input wire logic await_resp, // response expected
  input wire logic bus_idle, // line idle
  input wire logic bit_tick, // bit time pulse
  output logic [7:0] error_flags_q, // sticky error flags
  output logic error_pending_q, // any flag set
  output logic packet_reject_q, // packet rejected pulse
  output logic [31:0] table_base_q // descriptor table base
);

  logic [7:0] flags_d;
  logic [7:0] page2_q;
  logic [7:0] page2_d;
  logic [7:0] page3_q;
  logic [7:0] page3_d;
  logic [6:0] page1_q;
  logic [6:0] page1_d;
  logic [31:0] rdata_d;
  logic [31:0] base_d;
  logic reject_d;
  logic turn_timeout;

  // pid low nibble must be the complement of the high nibble
  function automatic logic pid_fails(input logic [7:0] pid);
    pid_fails = (pid[3:0] != ~pid[7:4]);
  endfunction : pid_fails

  uestb_turn_timer u_turn (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .eop_seen(eop_seen),
    .await_resp(await_resp),
    .bus_idle(bus_idle),
    .bit_tick(bit_tick),
    .timeout_q(turn_timeout)
  );

  // address decode
  wire hit_flags = (reg_addr == uestb_pkg::FLAGS_OFFSET);
  wire hit_page1 = (reg_addr == uestb_pkg::PAGE1_OFFSET);
  wire hit_page2 = (reg_addr == uestb_pkg::PAGE2_OFFSET);
  wire hit_page3 = (reg_addr == uestb_pkg::PAGE3_OFFSET);

  // event decode
  wire pid_bad = evt.pid_strobe && pid_fails(evt.pid_byte);
  wire size_bad = evt.data_end && (evt.data_bits_mod8 != 3'h0);
  wire crc16_bad = evt.data_end && evt.data_crc_bad;
  wire crc5_bad = !frame.host_mode && evt.token_end && evt.token_crc_bad;
  wire eof_bad = frame.host_mode && frame.sof_zero && (frame.tx_busy || frame.rx_busy);

  wire [7:0] set_vec;
  assign set_vec[uestb_pkg::BIT_STUFF_POS] = evt.bit_stuff;
  assign set_vec[uestb_pkg::BUS_MATRIX_POS] = evt.table_fault;
  assign set_vec[uestb_pkg::MEM_SERVICE_POS] = evt.grant_late || evt.rx_truncated;
  assign set_vec[uestb_pkg::TURNAROUND_POS] = turn_timeout;
  assign set_vec[uestb_pkg::DATA_SIZE_POS] = size_bad;
  assign set_vec[uestb_pkg::DATA_CRC_POS] = crc16_bad;
  assign set_vec[uestb_pkg::TOKEN_CRC_POS] = crc5_bad || eof_bad;
  assign set_vec[uestb_pkg::PID_CHECK_POS] = pid_bad;

  // write one clears, a same-cycle event wins
  wire [7:0] clr_vec = (reg_wr && hit_flags) ? reg_wdata[7:0] : 8'h00;
  assign flags_d = (error_flags_q & ~clr_vec) | set_vec;

  assign reject_d = evt.bit_stuff || crc16_bad || crc5_bad || pid_bad;

  // only the low byte is stored, bits 7 to 1 of it for page 1
  assign page1_d = (reg_wr && hit_page1) ? reg_wdata[7:1] : page1_q;
  assign page2_d = (reg_wr && hit_page2) ? reg_wdata[7:0] : page2_q;
  assign page3_d = (reg_wr && hit_page3) ? reg_wdata[7:0] : page3_q;

  assign base_d = {page3_q, page2_q, page1_q, uestb_pkg::BASE_LOW_ZERO};

  // read mux, unmapped and upper bits give zero
  wire [7:0] rd_byte = hit_flags ? error_flags_q :
                       hit_page1 ? {page1_q, 1'b0} :
                       hit_page2 ? page2_q :
                       hit_page3 ? page3_q : 8'h00;
  assign rdata_d = reg_rd ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      error_flags_q <= uestb_pkg::FLAGS_RESET;
      page1_q <= uestb_pkg::PAGE1_RESET;
      page2_q <= uestb_pkg::PAGE_RESET;
      page3_q <= uestb_pkg::PAGE_RESET;
      reg_rdata_q <= 32'h00000000;
      table_base_q <= 32'h00000000;
      packet_reject_q <= 1'b0;
      error_pending_q <= 1'b0;
    end else begin
      error_flags_q <= flags_d;
      page1_q <= page1_d;
      page2_q <= page2_d;
      page3_q <= page3_d;
      reg_rdata_q <= rdata_d;
      table_base_q <= base_d;
      packet_reject_q <= reject_d;
      error_pending_q <= |flags_d;
    end
  end

  // checks

  property p_bit_stuff;
    @(posedge sys_clk) disable iff (!arst_n)
    evt.bit_stuff |=> error_flags_q[7] && packet_reject_q;
  endproperty
  a_bit_stuff: assert property (p_bit_stuff) else $error("bit stuff flag not set");

  property p_bus_matrix;
    @(posedge sys_clk) disable iff (!arst_n)
    evt.table_fault |=> error_flags_q[6];
  endproperty
  a_bus_matrix: assert property (p_bus_matrix) else $error("bus matrix flag not set");

  property p_mem_service;
    @(posedge sys_clk) disable iff (!arst_n)
    (evt.grant_late || evt.rx_truncated) |=> error_flags_q[5];
  endproperty
  a_mem_service: assert property (p_mem_service) else $error("memory service flag not set");

  property p_turnaround;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(turn_timeout) |=> error_flags_q[4];
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("turnaround flag not set");

  property p_data_size;
    @(posedge sys_clk) disable iff (!arst_n)
    evt.data_end && (evt.data_bits_mod8 != 3'h0) |=> error_flags_q[3];
  endproperty
  a_data_size: assert property (p_data_size) else $error("data size flag not set");

  property p_data_crc;
    @(posedge sys_clk) disable iff (!arst_n)
    evt.data_end && evt.data_crc_bad |=> error_flags_q[2] && packet_reject_q;
  endproperty
  a_data_crc: assert property (p_data_crc) else $error("crc16 flag or reject missing");

  property p_token_crc;
    @(posedge sys_clk) disable iff (!arst_n)
    !frame.host_mode && evt.token_end && evt.token_crc_bad |=> error_flags_q[1] && packet_reject_q;
  endproperty
  a_token_crc: assert property (p_token_crc) else $error("crc5 flag or reject missing");

  property p_end_of_frame;
    @(posedge sys_clk) disable iff (!arst_n)
    frame.host_mode && frame.sof_zero && (frame.tx_busy || frame.rx_busy) |=> error_flags_q[1];
  endproperty
  a_end_of_frame: assert property (p_end_of_frame) else $error("eof flag not set");

  property p_pid_check;
    @(posedge sys_clk) disable iff (!arst_n)
    evt.pid_strobe && (evt.pid_byte[3:0] != ~evt.pid_byte[7:4]) |=> error_flags_q[0];
  endproperty
  a_pid_check: assert property (p_pid_check) else $error("pid flag not set");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !(reg_wr && hit_flags) |=> (error_flags_q & $past(error_flags_q)) == $past(error_flags_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr && hit_flags && (set_vec == 8'h00) |=> (error_flags_q & $past(reg_wdata[7:0])) == 8'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear");

  property p_upper_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_rd |=> reg_rdata_q[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  sequence s_page2_write;
    reg_wr && hit_page2 && !reg_rd;
  endsequence
  sequence s_page2_read;
    reg_rd && hit_page2 && !reg_wr;
  endsequence
  property p_page2_rw;
    logic [7:0] v;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_page2_write, v = reg_wdata[7:0]) ##1 s_page2_read |=> reg_rdata_q[7:0] == v;
  endproperty
  a_page2_rw: assert property (p_page2_rw) else $error("page 2 readback wrong");

  sequence s_page3_write;
    reg_wr && hit_page3;
  endsequence
  property p_page3_base;
    logic [7:0] v;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_page3_write, v = reg_wdata[7:0]) ##1 !(reg_wr && hit_page3) |=> table_base_q[31:24] == v;
  endproperty
  a_page3_base: assert property (p_page3_base) else $error("page 3 not in base");

  property p_base_align;
    @(posedge sys_clk) disable iff (!arst_n)
    table_base_q[8:0] == 9'h000 && table_base_q[23:16] == $past(page2_q);
  endproperty
  a_base_align: assert property (p_base_align) else $error("table base misformed");

  property p_base_page3;
    @(posedge sys_clk) disable iff (!arst_n)
    table_base_q[31:24] == $past(page3_q);
  endproperty
  a_base_page3: assert property (p_base_page3) else $error("page 3 not in base bits");

  property p_base_page1;
    @(posedge sys_clk) disable iff (!arst_n)
    table_base_q[15:9] == $past(page1_q);
  endproperty
  a_base_page1: assert property (p_base_page1) else $error("page 1 not in base bits");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata_q == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_flags_read;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_rd && hit_flags |=> reg_rdata_q[7:0] == $past(error_flags_q);
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag readback wrong");

  property p_page2_read;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_rd && hit_page2 |=> reg_rdata_q[7:0] == $past(page2_q);
  endproperty
  a_page2_read: assert property (p_page2_read) else $error("page 2 read wrong");

  property p_page3_read;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_rd && hit_page3 |=> reg_rdata_q[7:0] == $past(page3_q);
  endproperty
  a_page3_read: assert property (p_page3_read) else $error("page 3 read wrong");

  property p_unmapped_read;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_rd && !(hit_flags || hit_page1 || hit_page2 || hit_page3) |=> reg_rdata_q == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_rej_src;
    @(posedge sys_clk) disable iff (!arst_n)
    packet_reject_q |-> $past(evt.bit_stuff || (evt.data_end && evt.data_crc_bad) ||
      (!frame.host_mode && evt.token_end && evt.token_crc_bad) ||
      (evt.pid_strobe && (evt.pid_byte[3:0] != ~evt.pid_byte[7:4])));
  endproperty
  a_rej_src: assert property (p_rej_src) else $error("reject unexplained");

  property p_host_token;
    @(posedge sys_clk) disable iff (!arst_n)
    frame.host_mode && evt.token_end && evt.token_crc_bad && !evt.bit_stuff &&
      !evt.data_end && !evt.pid_strobe |=> !packet_reject_q;
  endproperty
  a_host_token: assert property (p_host_token) else $error("host token rejected");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr && hit_flags |=> (error_flags_q & $past(set_vec)) == $past(set_vec);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_rise_src;
    @(posedge sys_clk) disable iff (!arst_n)
    (error_flags_q & ~$past(error_flags_q) & ~$past(set_vec)) == 8'h00;
  endproperty
  a_rise_src: assert property (p_rise_src) else $error("flag set without event");

  property p_page2_write;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr && hit_page2 |=> page2_q == $past(reg_wdata[7:0]);
  endproperty
  a_page2_write: assert property (p_page2_write) else $error("page 2 write lost");

  property p_page3_write;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr && hit_page3 |=> page3_q == $past(reg_wdata[7:0]);
  endproperty
  a_page3_write: assert property (p_page3_write) else $error("page 3 write lost");

  property p_page1_write;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr && hit_page1 |=> page1_q == $past(reg_wdata[7:1]);
  endproperty
  a_page1_write: assert property (p_page1_write) else $error("page 1 write lost");

  property p_page2_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !(reg_wr && hit_page2) |=> $stable(page2_q);
  endproperty
  a_page2_hold: assert property (p_page2_hold) else $error("page 2 changed unwritten");

  property p_page3_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !(reg_wr && hit_page3) |=> $stable(page3_q);
  endproperty
  a_page3_hold: assert property (p_page3_hold) else $error("page 3 changed unwritten");

  property p_timeout_src;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(error_flags_q[4]) |-> $past(turn_timeout);
  endproperty
  a_timeout_src: assert property (p_timeout_src) else $error("bit 4 set without time-out");

  property p_bit1_src;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(error_flags_q[1]) |-> $past(frame.host_mode ? frame.sof_zero && (frame.tx_busy ||
      frame.rx_busy) : evt.token_end && evt.token_crc_bad);
  endproperty
  a_bit1_src: assert property (p_bit1_src) else $error("bit 1 set for wrong mode");

endmodule : uestb_core

//--- uestb_engine_model.sv
/* uestb_engine_model: packet engine stand-in driving events, frame status
   and idle bit times. Assumes its tasks are called from the bench. */
module uestb_engine_model (
  input wire logic sys_clk, // system clock
  output uestb_pkg::uestb_evt_type evt, // packet events
  output uestb_pkg::uestb_frame_type frame, // frame status
  output logic eop_seen, // end of packet
  output logic await_resp, // reply expected
  output logic bus_idle, // line idle
  output logic bit_tick // bit time
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    evt = '0;
    frame = '0;
    eop_seen = 1'b0;
    await_resp = 1'b0;
    bus_idle = 1'b0;
    bit_tick = 1'b0;
  end
  // one-cycle event beside its frame status
  task automatic pulse(input logic [19:0] e, input logic [3:0] f);
    @(posedge sys_clk);
    evt <= e;
    frame <= f;
    @(posedge sys_clk);
    evt <= '0;
    frame <= '0;
  endtask : pulse
  // optional end of packet, then n idle bit times awaiting a reply
  task automatic ticks(input logic eop, input int n);
    @(posedge sys_clk);
    eop_seen <= eop;
    await_resp <= 1'b1;
    bus_idle <= 1'b1;
    repeat (n) begin
      @(posedge sys_clk);
      eop_seen <= 1'b0;
      bit_tick <= 1'b1;
      @(posedge sys_clk);
      bit_tick <= 1'b0;
    end
  endtask : ticks
  // line busy, no reply awaited
  task automatic rest();
    @(posedge sys_clk);
    await_resp <= 1'b0;
    bus_idle <= 1'b0;
  endtask : rest
endmodule : uestb_engine_model

//--- test_usb_error_status_and_table_base.sv
/* test_usb_error_status_and_table_base: self-checking bench for uestb_core.
   Assumes uestb_pkg and uestb_engine_model are compiled first. */
module test_usb_error_status_and_table_base;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [19:0] ev;
    logic [3:0] fr;
    logic [7:0] fl;
    logic rj;
  } uestb_row_type;
  // event, frame status, expected flags, expected reject
  uestb_row_type rows [17] = '{
    '{20'h80000, 4'h0, 8'h80, 1'b1},
    '{20'h40000, 4'h0, 8'h40, 1'b0},
    '{20'h20000, 4'h0, 8'h20, 1'b0},
    '{20'h10000, 4'h0, 8'h20, 1'b0},
    '{20'h0B000, 4'h0, 8'h08, 1'b0},
    '{20'h08800, 4'h0, 8'h04, 1'b1},
    '{20'h08000, 4'h0, 8'h00, 1'b0},
    '{20'h0F800, 4'h0, 8'h0C, 1'b1},
    '{20'h00600, 4'h0, 8'h02, 1'b1},
    '{20'h00600, 4'h8, 8'h00, 1'b0},
    '{20'h00000, 4'hE, 8'h02, 1'b0},
    '{20'h00000, 4'hD, 8'h02, 1'b0},
    '{20'h00000, 4'hC, 8'h00, 1'b0},
    '{20'h00000, 4'h6, 8'h00, 1'b0},
    '{20'h00168, 4'h0, 8'h01, 1'b1},
    '{20'h00169, 4'h0, 8'h00, 1'b0},
    '{20'h00068, 4'h0, 8'h00, 1'b0}
  };
  logic sys_clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata_q;
  uestb_pkg::uestb_evt_type evt;
  uestb_pkg::uestb_frame_type frame;
  logic eop_seen, await_resp, bus_idle, bit_tick;
  logic [7:0] error_flags_q;
  logic error_pending_q;
  logic packet_reject_q;
  logic [31:0] table_base_q;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  uestb_engine_model eng (.sys_clk(sys_clk), .evt(evt), .frame(frame),
    .eop_seen(eop_seen), .await_resp(await_resp), .bus_idle(bus_idle),
    .bit_tick(bit_tick));
  uestb_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .evt(evt), .frame(frame), .eop_seen(eop_seen),
    .await_resp(await_resp), .bus_idle(bus_idle), .bit_tick(bit_tick),
    .error_flags_q(error_flags_q), .error_pending_q(error_pending_q),
    .packet_reject_q(packet_reject_q), .table_base_q(table_base_q));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", exp, reg_rdata_q);
  endtask : rd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk("base", 32'h0, table_base_q);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
    foreach (rows[i]) begin
      eng.pulse(rows[i].ev, rows[i].fr);
      @(negedge sys_clk);
      chk("flags", 32'(rows[i].fl), 32'(error_flags_q));
      chk("reject", 32'(rows[i].rj), 32'(packet_reject_q));
      rd(uestb_pkg::FLAGS_OFFSET, 32'(rows[i].fl));
      chk("pending", 32'(|rows[i].fl), 32'(error_pending_q));
      wr(uestb_pkg::FLAGS_OFFSET, 32'hFFFF_FFFF);
      rd(uestb_pkg::FLAGS_OFFSET, 32'h0);
      chk("pending", 32'h0, 32'(error_pending_q));
    end
    // set and clear in one cycle, then a write of zero to bit 7
    fork
      eng.pulse(20'h80000, 4'h0);
      wr(uestb_pkg::FLAGS_OFFSET, 32'h0000_0080);
    join
    wr(uestb_pkg::FLAGS_OFFSET, 32'hFFFF_FF7F);
    rd(uestb_pkg::FLAGS_OFFSET, 32'h80);
    wr(uestb_pkg::FLAGS_OFFSET, 32'h80);
    rd(uestb_pkg::FLAGS_OFFSET, 32'h0);
    wr(uestb_pkg::PAGE2_OFFSET, 32'h1234_56A5);
    wr(uestb_pkg::PAGE3_OFFSET, 32'hFFFF_FF3C);
    wr(uestb_pkg::PAGE1_OFFSET, 32'h0000_00FF);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(uestb_pkg::PAGE2_OFFSET, 32'hA5);
    rd(uestb_pkg::PAGE3_OFFSET, 32'h3C);
    rd(uestb_pkg::PAGE1_OFFSET, 32'hFE);
    rd(8'h10, 32'h0);
    chk("base", 32'h3CA5_FE00, table_base_q);
    // write then read with no gap, then the idle read data
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= uestb_pkg::PAGE2_OFFSET;
    reg_wdata <= 32'h0000_005A;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", 32'h5A, reg_rdata_q);
    @(negedge sys_clk);
    chk("rdata", 32'h0, reg_rdata_q);
    chk("base", 32'h3C5A_FE00, table_base_q);
    eng.ticks(1'b1, 16);
    repeat (4) @(negedge sys_clk);
    chk("flags", 32'h0, 32'(error_flags_q));
    eng.ticks(1'b0, 1);
    @(negedge sys_clk);
    chk("flags", 32'h0, 32'(error_flags_q));
    repeat (2) @(negedge sys_clk);
    chk("flags", 32'h10, 32'(error_flags_q));
    wr(uestb_pkg::FLAGS_OFFSET, 32'h10);
    // leaving idle disarms until the next end of packet
    eng.ticks(1'b1, 10);
    eng.rest();
    eng.ticks(1'b0, 10);
    repeat (4) @(negedge sys_clk);
    chk("flags", 32'h0, 32'(error_flags_q));
    eng.rest();
    eng.pulse(20'h40000, 4'h0);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("base", 32'h0, table_base_q);
    chk("flags", 32'h0, 32'(error_flags_q));
    arst_n <= 1'b1;
    rd(uestb_pkg::PAGE3_OFFSET, 32'h0);
    rd(uestb_pkg::FLAGS_OFFSET, 32'h0);
    print_verdict();
  end
endmodule : test_usb_error_status_and_table_base
